//--- src/asr_cnt.sv
// down counter used to time pin phases
// assumes a synchronous active-low reset copy and a clock enable
`timescale 1ns/100ps
module asr_cnt
    import asr_pkg::*;
(
    input  wire logic       clk_i,   // clock
    input  wire logic       rst_n_i, // synchronised reset
    input  wire logic       ce_i,    // clock enable
    input  wire logic       load_i,  // load the count
    input  wire logic [3:0] val_i,   // count to load
    output logic            done_o   // count has run out
);
    logic [3:0] cnt_q;

    // load or count down to zero
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= ASR_CNT_RST;
        end else if (ce_i) begin
            if (load_i) begin
                cnt_q <= val_i;
            end else if (cnt_q != ASR_CNT_RST) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end

    // done reads the count only, so a load that depends on done makes no loop
    assign done_o = (cnt_q == ASR_CNT_RST);
endmodule : asr_cnt

//--- src/asr_host.sv
// host controller for an asynchronous 128k x 8 static memory
// assumes the memory pins are wired straight to this block's pins and the
// data inputs are synchronous to mclk_i
//
// Behaviour
// [RQ1] memory holds 131072 bytes, 17-bit address, one shared 8-bit data port
// [RQ2] select high: memory floats data and powers down
// [RQ3] select low, gate low, strobe high: memory drives the stored byte
// [RQ4] select low, strobe low: memory stores the data lines, gate ignored
// [RQ5] selected with gate and strobe high: data outputs stay floating
// [RQ6] internal write lasts while select and strobe are both low
// [RQ7] host times data set-up and hold to the first rising of select or strobe
// [RQ8] select and strobe rising together: memory outputs stay floating
// [RQ9] strobe write with gate low lasts at least turn-off plus data set-up
// [RQ10] with gate low host drives data only after the memory releases it
// [RQ11] read data valid at most 8 to 15 ns after address settles
// [RQ12] previous read data stays valid 3 ns after the address changes
// [RQ13] host keeps strobe high through every read
// [RQ14] address stable no later than the write begins
// [RQ15] address stable 7 to 10 ns before the write ends, zero hold
// [RQ16] write data valid 5 to 8 ns before the write-ending edge
// [RQ17] host may drop write data right at the write-ending edge
// [RQ18] memory output turn-off is faster than turn-on for each control
// [RQ19] for select-started reads the address is valid when select falls
// [RQ20] selected with gate low, memory follows each new address
`timescale 1ns/100ps
module asr_host
    import asr_pkg::*;
(
    input  wire logic              mclk_i,       // 125 MHz clock
    input  wire logic              arst_n_i,     // async reset, active low
    input  wire logic              ce_i,         // clock enable
    input  wire logic              req_i,        // access request
    input  wire logic              wr_i,         // 1 write, 0 read
    input  wire logic [ASR_AW-1:0] addr_i,       // access address
    input  wire logic [ASR_DW-1:0] wdata_i,      // write byte
    input  wire logic              gate_low_i,   // keep output gate low in writes
    output logic                   busy_o,       // access in progress
    output logic                   done_o,       // access finished pulse
    output logic [ASR_DW-1:0]      rdata_o,      // read byte
    output logic [ASR_AW-1:0]      addr_lines_o, // memory address
    output logic                   cs_n_o,       // chip_select_n
    output logic                   oe_n_o,       // output_gate_n
    output logic                   we_n_o,       // write_strobe_n
    input  wire logic [ASR_DW-1:0] data_lines_i, // data lines in
    output logic [ASR_DW-1:0]      data_lines_o, // data lines out
    output logic                   data_oe_o     // high while host drives data
);
    logic             rst_s1_q;
    logic             rst_n_q;
    asr_state_t       st_q;
    logic             wr_gate_q;
    logic             cnt_load;
    logic [3:0]       cnt_val;
    logic             cnt_done;

    // reset release through two flops
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // phase timer
    asr_cnt u_cnt (
        .clk_i   (mclk_i),
        .rst_n_i (rst_n_q),
        .ce_i    (ce_i),
        .load_i  (cnt_load),
        .val_i   (cnt_val),
        .done_o  (cnt_done)
    );

    // timer loads on entry to RDAC, WRSET and WRSTB
    always_comb begin
        cnt_load = 1'b0;
        cnt_val  = ASR_CNT_RST;
        unique case (st_q)
            ASR_IDLE: begin
                cnt_load = req_i;
                cnt_val  = wr_i ? ASR_CNT_RST : ASR_RD_CYC;     // [RQ11]
            end
            ASR_WRSET: begin
                cnt_load = cnt_done;
                cnt_val  = ASR_WR_CYC;                          // [RQ16]
            end
            ASR_RDAC, ASR_WRSTB, ASR_WREND: begin
                cnt_load = 1'b0;
                cnt_val  = ASR_CNT_RST;
            end
            default: begin
                cnt_load = 1'b0;
                cnt_val  = ASR_CNT_RST;
            end
        endcase
    end

    // sequence of pin phases
    always_ff @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q      <= ASR_IDLE;
            wr_gate_q <= 1'b0;
        end else if (ce_i) begin
            unique case (st_q)
                ASR_IDLE: begin
                    if (req_i) begin
                        st_q      <= wr_i ? ASR_WRSET : ASR_RDAC;
                        wr_gate_q <= gate_low_i;
                    end
                end
                ASR_RDAC: begin
                    if (cnt_done) st_q <= ASR_IDLE;
                end
                ASR_WRSET: begin
                    if (cnt_done) st_q <= ASR_WRSTB;
                end
                ASR_WRSTB: begin
                    if (cnt_done) st_q <= ASR_WREND;
                end
                ASR_WREND: begin
                    st_q <= ASR_IDLE;
                end
                default: begin
                    st_q <= ASR_IDLE;
                end
            endcase
        end
    end

    // memory control pins
    always_ff @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cs_n_o       <= 1'b1;
            oe_n_o       <= 1'b1;
            we_n_o       <= 1'b1;
            addr_lines_o <= ASR_ADDR_RST;
        end else if (ce_i) begin
            unique case (st_q)
                ASR_IDLE: begin
                    if (req_i) begin
                        addr_lines_o <= addr_i;                  // [RQ14] [RQ19]
                        cs_n_o       <= 1'b0;
                        oe_n_o       <= wr_i ? !gate_low_i : 1'b0;
                        we_n_o       <= 1'b1;                    // [RQ13]
                    end else begin
                        cs_n_o <= 1'b1;
                        oe_n_o <= 1'b1;
                        we_n_o <= 1'b1;
                    end
                end
                ASR_RDAC: begin
                    if (cnt_done) begin
                        cs_n_o <= 1'b1;
                        oe_n_o <= 1'b1;
                    end
                end
                ASR_WRSET: begin
                    if (cnt_done) we_n_o <= 1'b0;                // [RQ6]
                end
                ASR_WRSTB: begin
                    if (cnt_done) begin
                        we_n_o <= 1'b1;                          // [RQ7] [RQ15]
                        cs_n_o <= 1'b1;                          // [RQ8]
                        oe_n_o <= 1'b1;
                    end
                end
                ASR_WREND: begin
                    cs_n_o <= 1'b1;
                end
                default: begin
                    cs_n_o <= 1'b1;
                end
            endcase
        end
    end

    // host data drive, delayed after strobe falls when the gate is low
    always_ff @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            data_lines_o <= ASR_DATA_RST;
            data_oe_o    <= 1'b0;
        end else if (ce_i) begin
            if (st_q == ASR_IDLE && req_i && wr_i) begin
                data_lines_o <= wdata_i;
            end
            if (st_q == ASR_WRSET && !wr_gate_q) begin
                data_oe_o <= 1'b1;
            end else if (st_q == ASR_WRSTB && !we_n_o) begin
                data_oe_o <= 1'b1;                               // [RQ10] [RQ9]
            end else if (st_q == ASR_WREND || st_q == ASR_IDLE) begin
                data_oe_o <= 1'b0;                               // [RQ17]
            end
        end
    end

    // handshake and read capture
    always_ff @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            busy_o  <= 1'b0;
            done_o  <= 1'b0;
            rdata_o <= ASR_DATA_RST;
        end else if (ce_i) begin
            done_o <= 1'b0;
            if (st_q == ASR_IDLE && req_i) begin
                busy_o <= 1'b1;
            end
            if (st_q == ASR_RDAC && cnt_done) begin
                rdata_o <= data_lines_i;                         // [RQ11] [RQ20]
                busy_o  <= 1'b0;
                done_o  <= 1'b1;
            end
            if (st_q == ASR_WREND) begin
                busy_o <= 1'b0;
                done_o <= 1'b1;
            end
        end
    end

    // write strobe never low while reading
    strobe_read_a: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
        (st_q == ASR_RDAC) |-> we_n_o) else $error("strobe low in read"); // [RQ13]

    // host never drives data with the gate low before the strobe falls
    gate_drive_a: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
        (data_oe_o && !oe_n_o) |-> !we_n_o || $past(!we_n_o)) else $error("drive clash"); // [RQ10]

    // data driven at least two cycles before the strobe rises
    data_setup_a: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
        ($rose(we_n_o) && !cs_n_o) || ($rose(we_n_o) && $rose(cs_n_o))
        |-> $past(data_oe_o, 1) && $past(data_oe_o, 2)) else $error("data set-up short"); // [RQ16]

    // address stable while strobe is low
    addr_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
        (!we_n_o && $past(!we_n_o)) |-> $stable(addr_lines_o)) else $error("address moved"); // [RQ15]

    // a read finishes within its access count
    read_len_a: assert property (@(posedge mclk_i) disable iff (!rst_n_q || !ce_i)
        (st_q == ASR_IDLE && req_i && !wr_i) |=> ##[1:4] done_o) else $error("read too slow"); // [RQ11]

    // a write ends with select and strobe rising together
    write_end_a: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
        $rose(we_n_o) |-> $rose(cs_n_o)) else $error("write end split"); // [RQ8]
endmodule : asr_host

//--- src/asr_pkg.sv
// package for the static memory host controller
// holds pin widths, timing figures and derived cycle counts for a 125 MHz clock
package asr_pkg;
    localparam int          ASR_AW          = 17;     // address lines
    localparam int          ASR_DW          = 8;      // data lines
    localparam int          ASR_WORDS       = 131072; // locations
    localparam int          ASR_CLK_PS      = 8000;   // clock period in ps
    // timing figures in ps, slowest grade
    localparam int          ASR_ACCESS_PS   = 15000;  // addr_access_delay
    localparam int          ASR_HOLD_PS     = 3000;   // addr_change_hold
    localparam int          ASR_AW_PS       = 10000;  // addr_setup_to_write_end
    localparam int          ASR_SD_PS       = 8000;   // data_setup_to_write_end
    localparam int          ASR_OFF_PS      = 7000;   // strobe_low_output_off_delay
    localparam int          ASR_PWE_PS      = 10000;  // write strobe width
    // cycle counts, least times rounded up; the read count adds one cycle for pin sampling
    localparam int          ASR_RD_CYC_I    = (ASR_ACCESS_PS + ASR_CLK_PS - 1) / ASR_CLK_PS + 1;
    localparam int          ASR_OFF_CYC_I   = (ASR_OFF_PS + ASR_CLK_PS - 1) / ASR_CLK_PS;
    localparam int          ASR_WR_CYC_I    = (ASR_PWE_PS + ASR_CLK_PS - 1) / ASR_CLK_PS;
    localparam logic [3:0]  ASR_RD_CYC      = 4'(ASR_RD_CYC_I);
    localparam logic [3:0]  ASR_OFF_CYC     = 4'(ASR_OFF_CYC_I);
    localparam logic [3:0]  ASR_WR_CYC      = 4'(ASR_WR_CYC_I);
    localparam logic [3:0]  ASR_CNT_RST     = 4'h0;
    localparam logic [16:0] ASR_ADDR_RST    = 17'h00000;
    localparam logic [7:0]  ASR_DATA_RST    = 8'h00;

    typedef enum logic [2:0] {
        ASR_IDLE  = 3'b000,
        ASR_RDAC  = 3'b001,
        ASR_WRSET = 3'b010,
        ASR_WRSTB = 3'b011,
        ASR_WREND = 3'b100
    } asr_state_t;
endpackage : asr_pkg

//--- verif/asr_host_test.sv
// self-checking bench for the static memory host controller
// assumes the behavioural memory model answers on the far side
`timescale 1ns/100ps
module asr_host_test;
    import asr_pkg::*;
    logic              mclk_i     = 1'b0;
    logic              arst_n_i   = 1'b0;
    logic              ce_i       = 1'b1;
    logic              req_i      = 1'b0;
    logic              wr_i       = 1'b0;
    logic              gate_low_i = 1'b0;
    logic [ASR_AW-1:0] addr_i     = 17'h00000;
    logic [ASR_DW-1:0] wdata_i    = 8'h00;
    logic [ASR_DW-1:0] data_lines_i, data_lines_o, rdata_o;
    logic [ASR_AW-1:0] addr_lines_o;
    logic              busy_o, done_o, cs_n_o, oe_n_o, we_n_o, data_oe_o, clash;
    logic [ASR_DW-1:0] shadow [int];
    int                err_count  = 0;
    int                checks     = 0;
    // clock at 125 MHz
    always #4 mclk_i = ~mclk_i;
    asr_host DUT (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .req_i(req_i), .wr_i(wr_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .gate_low_i(gate_low_i), .busy_o(busy_o), .done_o(done_o),
        .rdata_o(rdata_o), .addr_lines_o(addr_lines_o), .cs_n_o(cs_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o),
        .data_lines_i(data_lines_i), .data_lines_o(data_lines_o), .data_oe_o(data_oe_o));
    asr_mem_model mem (.clk_i(mclk_i), .addr_i(addr_lines_o), .cs_n_i(cs_n_o), .oe_n_i(oe_n_o),
        .we_n_i(we_n_o), .host_d_i(data_lines_o), .host_oe_i(data_oe_o), .bus_o(data_lines_i),
        .clash_o(clash));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report;
        if (err_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report
    // one access with per-cycle pin checks; stall freezes ce_i, poke retries while busy
    task automatic access(input logic w, input logic [16:0] a, input logic [7:0] d, input logic g,
                          input int stall, input logic poke);
        int n;
        int wl;
        int wd;
        wl = 0;
        wd = 0;
        @(negedge mclk_i);
        req_i = 1'b1; wr_i = w; addr_i = a; wdata_i = d; gate_low_i = g;
        @(negedge mclk_i);
        req_i = 1'b0;
        ce_i = (stall == 0);
        for (n = 1; n < 40; n++) begin
            check(clash, 1'b0);
            if (n == 1) check({cs_n_o, oe_n_o, addr_lines_o}, {1'b0, w && !g, a});
            if (!w) check(we_n_o, 1'b1);
            if (we_n_o === 1'b0) begin
                wl++;
                check({cs_n_o, addr_lines_o}, {1'b0, a});
                if (data_oe_o === 1'b1) begin
                    wd++;
                    check(data_lines_o, d);
                end
            end
            if (done_o === 1'b1) break;
            if (n == stall + 1) ce_i = 1'b1;
            if (poke && n == 2) begin
                req_i = 1'b1; addr_i = a ^ 17'h00001;
            end
            if (poke && n == 3) req_i = 1'b0;
            @(negedge mclk_i);
        end
        check(n, (w ? 6 : ASR_RD_CYC + 2) + stall);
        if (w) begin
            check(wl >= ASR_WR_CYC, 1'b1);
            check(wd > 0, 1'b1);
            shadow[a] = d;
        end else begin
            check(rdata_o, shadow[a]);
        end
        @(negedge mclk_i);
        check({busy_o, cs_n_o, we_n_o, data_oe_o}, 4'h6);
    endtask : access
    task automatic t_reset;
        check({cs_n_o, oe_n_o, we_n_o, data_oe_o, busy_o, done_o}, 6'h38);
    endtask : t_reset
    task automatic t_edges;
        access(1'b1, 17'h00000, 8'h3c, 1'b0, 0, 1'b0);
        access(1'b1, 17'h1ffff, 8'hc3, 1'b0, 0, 1'b0);
        access(1'b0, 17'h00000, 8'h00, 1'b0, 0, 1'b0);
        access(1'b0, 17'h1ffff, 8'h00, 1'b0, 0, 1'b0);
    endtask : t_edges
    task automatic t_gate_low;
        access(1'b1, 17'h0aa55, 8'h96, 1'b1, 0, 1'b0);
        access(1'b1, 17'h0aa55, 8'h69, 1'b1, 0, 1'b0);
        access(1'b0, 17'h0aa55, 8'h00, 1'b0, 0, 1'b0);
    endtask : t_gate_low
    task automatic t_stall_refuse;
        access(1'b1, 17'h00001, 8'hff, 1'b0, 3, 1'b0);
        access(1'b0, 17'h00001, 8'h00, 1'b0, 2, 1'b0);
        access(1'b0, 17'h00000, 8'h00, 1'b0, 0, 1'b1);
    endtask : t_stall_refuse
    // watchdog
    initial begin
        #100000;
        err_count++;
        final_report();
    end
    initial begin
        repeat (3) @(negedge mclk_i);
        t_reset();
        arst_n_i = 1'b1;
        repeat (3) @(negedge mclk_i);
        t_edges();
        t_gate_low();
        t_stall_refuse();
        final_report();
    end
endmodule : asr_host_test

//--- verif/asr_mem_model.sv
// behavioural 128k x 8 static memory standing on the far side of the host
// assumes its pins come straight from the host; clk_i only animates a released bus
`timescale 1ns/100ps
module asr_mem_model
    import asr_pkg::*;
(
    input  wire logic              clk_i,     // float pattern clock
    input  wire logic [ASR_AW-1:0] addr_i,    // addr_lines
    input  wire logic              cs_n_i,    // chip_select_n
    input  wire logic              oe_n_i,    // output_gate_n
    input  wire logic              we_n_i,    // write_strobe_n
    input  wire logic [ASR_DW-1:0] host_d_i,  // host drive value
    input  wire logic              host_oe_i, // host drives data_lines
    output logic [ASR_DW-1:0]      bus_o,     // resolved data_lines level
    output logic                   clash_o    // both sides drive at once
);
    logic [ASR_DW-1:0] mem [ASR_WORDS];
    logic [ASR_DW-1:0] rd;
    logic [ASR_DW-1:0] flt_q = 8'h5a;
    wire               drv;
    wire               wr_act;
    // drive only when selected, gate low, strobe high; turn-off beats turn-on
    assign #(3, 0) drv = !cs_n_i && !oe_n_i && we_n_i;
    // stored byte follows the address after the access delay, old byte held meanwhile
    assign #15 rd = mem[addr_i];
    // a write is the overlap of select and strobe; the byte lands at its end
    assign wr_act = !cs_n_i && !we_n_i;
    always @(negedge wr_act) mem[addr_i] = bus_o;
    // a released bus shows a pattern that changes every cycle
    always @(posedge clk_i) flt_q <= ~flt_q;
    assign bus_o   = host_oe_i ? host_d_i : (drv ? rd : flt_q);
    assign clash_o = host_oe_i && drv;
endmodule : asr_mem_model
